//--- core/port_pin_function_select.sv
// Pin function multiplexer for port-1 pin 7 and port-2 pins 0..7 with AHB-Lite registers.
// Assumes pins arrive asynchronously; peripherals share clk_in.
// Operation
// - P1 pin 7 GPIO or timer output 2
// - Test access overrides P1 pin 7
// - Reset leaves pins GPIO except P2 pins 6, 7 (crystal), overrides cleared
// - P2 pin0 aux clock, pin2 timer ch0
// - P2 pin1 timer clock in, sub-main out
// - P2 pin3 timer capture 1B, output 1
// - P2 pin4 drives timer output 2 only
// - Analog enable takes pins 0..4, drivers off
// - Resistor bit gives pin5 to oscillator
// - Pin5 select plus output drives ground
// - Pin6 select is crystal input, default
// - Pin7 select is crystal output, default
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "pin_mux_params.svh"
module port_pin_function_select import pin_mux_pkg::*; (
	input wire logic clk_in, // 20 MHz clock
	input wire logic reset_in, // async reset, high, power-up clear
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write strobe
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // response, always OKAY
	input wire logic p1_pin7_in, // pad input port-1 pin 7
	output logic p1_pin7_out, // pad output
	output logic p1_pin7_oe_out, // pad output enable
	input wire logic [7:0] p2_pin_in, // pad inputs port 2
	output pin_drive_s p2_drive_out, // pad outputs and enables
	output logic [7:0] p2_input_enable_out, // input buffer enables
	input wire logic test_port_active_in, // 4-wire test port active
	input wire logic test_data_out_in, // test data to drive
	input wire logic test_data_oe_in, // test controller drive enable
	output logic test_data_in_out, // test data from pin
	input periph_out_s periph_in, // on-chip sources
	output logic timer_a_capture_input_0b_out, // capture 0B
	output logic timer_a_capture_input_1b_out, // capture 1B
	output logic timer_a_external_input_clock_out, // timer clock input
	output logic [4:0] analog_channel_connect_out, // converter switch enables
	output logic oscillator_resistor_input_out, // resistor connected
	output logic crystal_input_out, // crystal in connected
	output logic crystal_output_out, // crystal out connected
	output logic irq_out // port-2 interrupt request
);
	logic [7:0] port1_direction_bits_q, port1_direction_bits_d;
	logic [7:0] port1_function_select_bits_q, port1_function_select_bits_d;
	logic [7:0] port2_direction_bits_q, port2_direction_bits_d;
	logic [7:0] port2_function_select_bits_q, port2_function_select_bits_d;
	logic [7:0] p1_out_q, p1_out_d, p2_out_q, p2_out_d;
	logic [`AN_EN_WIDTH-1:0] converter_analog_enable_bits_q, converter_analog_enable_bits_d;
	logic oscillator_external_resistor_select_q, oscillator_external_resistor_select_d;
	logic [7:0] port2_irq_enable_bits_q, port2_irq_enable_bits_d;
	logic [7:0] port2_edge_select_bits_q, port2_edge_select_bits_d;
	logic [7:0] flag_clear, flag_set, port2_irq_flag_bits;
	logic [11:0] addr_q, addr_d;
	bus_phase_e phase_q, phase_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] p2_meta_q, p2_sync_q;
	logic p1_meta_q, p1_sync_q;
	logic [7:0] an_full, gpio_in_mode;
	logic [7:0] p2_out_c, p2_oe_c;

	// Two-stage synchronisers for the pad inputs.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			p2_meta_q <= 8'h00;
			p2_sync_q <= 8'h00;
			p1_meta_q <= 1'b0;
			p1_sync_q <= 1'b0;
		end else begin
			p2_meta_q <= p2_pin_in;
			p2_sync_q <= p2_meta_q;
			p1_meta_q <= p1_pin7_in;
			p1_sync_q <= p1_meta_q;
		end
	end

	// Bus slave: capture the address phase, act in the data phase.
	always_comb begin
		phase_d = BUS_IDLE;
		addr_d = addr_q;
		if (hready && hsel && htrans[1]) begin
			phase_d = hwrite ? BUS_WRITE : BUS_READ;
			addr_d = haddr[11:0];
		end
	end

	always_comb begin
		port1_direction_bits_d = port1_direction_bits_q;
		port1_function_select_bits_d = port1_function_select_bits_q;
		port2_direction_bits_d = port2_direction_bits_q;
		port2_function_select_bits_d = port2_function_select_bits_q;
		p1_out_d = p1_out_q;
		p2_out_d = p2_out_q;
		converter_analog_enable_bits_d = converter_analog_enable_bits_q;
		oscillator_external_resistor_select_d = oscillator_external_resistor_select_q;
		port2_irq_enable_bits_d = port2_irq_enable_bits_q;
		port2_edge_select_bits_d = port2_edge_select_bits_q;
		flag_clear = 8'h00;
		flag_set = 8'h00;
		if (phase_q == BUS_WRITE) begin
			case (addr_q)
				`ADDR_P1_DIR: port1_direction_bits_d = hwdata[7:0];
				`ADDR_P1_SEL: port1_function_select_bits_d = hwdata[7:0];
				`ADDR_P2_DIR: port2_direction_bits_d = hwdata[7:0];
				`ADDR_P2_SEL: port2_function_select_bits_d = hwdata[7:0];
				`ADDR_P2_OUT: p2_out_d = hwdata[7:0];
				`ADDR_P1_OUT: p1_out_d = hwdata[7:0];
				`ADDR_AN_EN: converter_analog_enable_bits_d = hwdata[`AN_EN_WIDTH-1:0];
				`ADDR_OSC_RES: oscillator_external_resistor_select_d = hwdata[0];
				`ADDR_IRQ_EN: port2_irq_enable_bits_d = hwdata[7:0];
				`ADDR_EDGE_SEL: port2_edge_select_bits_d = hwdata[7:0];
				`ADDR_IRQ_FLAG: begin
					flag_clear = ~hwdata[7:0];
					flag_set = hwdata[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (phase_d == BUS_READ) begin
			case (haddr[11:0])
				`ADDR_P1_DIR: rdata_d[7:0] = port1_direction_bits_d;
				`ADDR_P1_SEL: rdata_d[7:0] = port1_function_select_bits_d;
				`ADDR_P2_DIR: rdata_d[7:0] = port2_direction_bits_d;
				`ADDR_P2_SEL: rdata_d[7:0] = port2_function_select_bits_d;
				`ADDR_P2_OUT: rdata_d[7:0] = p2_out_d;
				`ADDR_P1_OUT: rdata_d[7:0] = p1_out_d;
				`ADDR_AN_EN: rdata_d[`AN_EN_WIDTH-1:0] = converter_analog_enable_bits_d;
				`ADDR_OSC_RES: rdata_d[0] = oscillator_external_resistor_select_d;
				`ADDR_IRQ_EN: rdata_d[7:0] = port2_irq_enable_bits_d;
				`ADDR_EDGE_SEL: rdata_d[7:0] = port2_edge_select_bits_d;
				`ADDR_IRQ_FLAG: rdata_d[7:0] = port2_irq_flag_bits;
				`ADDR_PIN_IN: rdata_d[8:0] = {p1_sync_q, p2_sync_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			phase_q <= BUS_IDLE;
			addr_q <= 12'h000;
			rdata_q <= 32'h0000_0000;
			port1_direction_bits_q <= 8'h00;
			port1_function_select_bits_q <= 8'h00;
			port2_direction_bits_q <= 8'h00;
			port2_function_select_bits_q <= `P2_SEL_RESET;
			p1_out_q <= 8'h00;
			p2_out_q <= 8'h00;
			converter_analog_enable_bits_q <= '0;
			oscillator_external_resistor_select_q <= 1'b0;
			port2_irq_enable_bits_q <= 8'h00;
			port2_edge_select_bits_q <= 8'h00;
		end else begin
			phase_q <= phase_d;
			addr_q <= addr_d;
			rdata_q <= rdata_d;
			port1_direction_bits_q <= port1_direction_bits_d;
			port1_function_select_bits_q <= port1_function_select_bits_d;
			port2_direction_bits_q <= port2_direction_bits_d;
			port2_function_select_bits_q <= port2_function_select_bits_d;
			p1_out_q <= p1_out_d;
			p2_out_q <= p2_out_d;
			converter_analog_enable_bits_q <= converter_analog_enable_bits_d;
			oscillator_external_resistor_select_q <= oscillator_external_resistor_select_d;
			port2_irq_enable_bits_q <= port2_irq_enable_bits_d;
			port2_edge_select_bits_q <= port2_edge_select_bits_d;
		end
	end

	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Port-1 pin 7.
	always_comb begin
		if (test_port_active_in) begin
			p1_pin7_out = test_data_out_in;
			p1_pin7_oe_out = test_data_oe_in;
		end else if (port1_function_select_bits_q[`BIT_P1_PIN7]) begin
			p1_pin7_out = periph_in.timer_a_output_2;
			p1_pin7_oe_out = port1_direction_bits_q[`BIT_P1_PIN7];
		end else begin
			p1_pin7_out = p1_out_q[`BIT_P1_PIN7];
			p1_pin7_oe_out = port1_direction_bits_q[`BIT_P1_PIN7];
		end
	end
	assign test_data_in_out = test_port_active_in & p1_sync_q;

	// Port-2 pins.
	assign an_full = {3'b000, converter_analog_enable_bits_q};
	always_comb begin
		p2_out_c = p2_out_q;
		p2_oe_c = port2_direction_bits_q;
		// aux clock, sub-main clock and timer outputs 0..2
		if (port2_function_select_bits_q[0]) p2_out_c[0] = periph_in.aux_clock;
		if (port2_function_select_bits_q[1]) p2_out_c[1] = periph_in.sub_main_clock;
		if (port2_function_select_bits_q[2]) p2_out_c[2] = periph_in.timer_a_output_0;
		if (port2_function_select_bits_q[3]) p2_out_c[3] = periph_in.timer_a_output_1;
		if (port2_function_select_bits_q[4]) begin
			p2_out_c[4] = periph_in.timer_a_output_2;
		end
		if (port2_function_select_bits_q[`BIT_P2_OSC_RES]) p2_out_c[5] = 1'b0;
		if (port2_function_select_bits_q[`BIT_P2_XIN]) p2_oe_c[6] = 1'b0;
		if (port2_function_select_bits_q[`BIT_P2_CRYSTAL_OUTPUT]) p2_oe_c[7] = 1'b0;
		p2_oe_c = p2_oe_c & ~an_full;
		if (oscillator_external_resistor_select_q) p2_oe_c[5] = 1'b0;
	end
	assign p2_drive_out.out = p2_out_c;
	assign p2_drive_out.oe = p2_oe_c;
	assign p2_input_enable_out = ~an_full &
		~{2'b00, oscillator_external_resistor_select_q, 5'b00000} &
		~(port2_function_select_bits_q & 8'hc0);
	assign analog_channel_connect_out = converter_analog_enable_bits_q;
	assign oscillator_resistor_input_out = oscillator_external_resistor_select_q;
	assign crystal_input_out = port2_function_select_bits_q[`BIT_P2_XIN];
	assign crystal_output_out = port2_function_select_bits_q[`BIT_P2_CRYSTAL_OUTPUT];

	assign gpio_in_mode = ~port2_direction_bits_q & p2_input_enable_out;
	assign timer_a_capture_input_0b_out = port2_function_select_bits_q[2] & gpio_in_mode[2] &
		p2_sync_q[2];
	assign timer_a_capture_input_1b_out = port2_function_select_bits_q[3] & gpio_in_mode[3] &
		p2_sync_q[3];
	assign timer_a_external_input_clock_out = port2_function_select_bits_q[1] &
		gpio_in_mode[1] & p2_sync_q[1];

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_edge
			pin_edge_detect u_edge (
				.clk_in(clk_in),
				.reset_in(reset_in),
				.pin_in(p2_sync_q[gi]),
				.arm_in(gpio_in_mode[gi] & ~port2_function_select_bits_q[gi]),
				.falling_in(port2_edge_select_bits_q[gi]),
				.clear_in(flag_clear[gi]),
				.set_in(flag_set[gi]),
				.flag_out(port2_irq_flag_bits[gi])
			);
		end
	endgenerate
	assign irq_out = |(port2_irq_flag_bits & port2_irq_enable_bits_q);

	a_test_pin_owner: assert property (@(posedge clk_in) disable iff (reset_in)
		test_port_active_in |-> p1_pin7_oe_out == test_data_oe_in) else $error("test port lost pin");
	a_analog_driver_off: assert property (@(posedge clk_in) disable iff (reset_in)
		|(an_full & p2_oe_c) == 1'b0) else $error("driver on analog pin");
	a_resistor_pin_quiet: assert property (@(posedge clk_in) disable iff (reset_in)
		oscillator_external_resistor_select_q |-> !p2_oe_c[5]) else $error("pin5 driven");
	a_ground_drive_pin: assert property (@(posedge clk_in) disable iff (reset_in)
		port2_function_select_bits_q[5] && port2_direction_bits_q[5] &&
		!oscillator_external_resistor_select_q |-> p2_oe_c[5] && !p2_out_c[5])
		else $error("pin5 not grounded");
	a_p1_timer_drive: assert property (@(posedge clk_in) disable iff (reset_in)
		!test_port_active_in && port1_function_select_bits_q[7] && port1_direction_bits_q[7]
		|-> p1_pin7_out == periph_in.timer_a_output_2) else $error("pin7 timer wrong");
	a_crystal_pins_off: assert property (@(posedge clk_in) disable iff (reset_in)
		port2_function_select_bits_q[7] |-> !p2_oe_c[7] && crystal_output_out)
		else $error("crystal pin driven");
	a_crystal_in_off: assert property (@(posedge clk_in) disable iff (reset_in)
		port2_function_select_bits_q[6] |-> !p2_oe_c[6] && crystal_input_out)
		else $error("crystal input driven");
	a_irq_needs_enable: assert property (@(posedge clk_in) disable iff (reset_in)
		port2_irq_enable_bits_q == 8'h00 |-> !irq_out) else $error("masked irq raised");
	a_sel_write_lands: assert property (@(posedge clk_in) disable iff (reset_in)
		phase_q == BUS_WRITE && addr_q == `ADDR_P2_SEL |=> port2_function_select_bits_q ==
		$past(hwdata[7:0])) else $error("select write lost");
endmodule

//--- core/pin_mux_params.svh
// Constants for the port pin function select block.
// Assumes inclusion by the main module and the bench only.
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH
`define ADDR_P1_DIR 12'h000
`define ADDR_P1_SEL 12'h004
`define ADDR_P2_DIR 12'h008
`define ADDR_P2_SEL 12'h00c
`define ADDR_P2_OUT 12'h010
`define ADDR_P1_OUT 12'h014
`define ADDR_AN_EN 12'h018
`define ADDR_OSC_RES 12'h01c
`define ADDR_IRQ_EN 12'h020
`define ADDR_EDGE_SEL 12'h024
`define ADDR_IRQ_FLAG 12'h028
`define ADDR_PIN_IN 12'h02c
`define P2_SEL_RESET 8'hc0
`define BIT_P1_PIN7 7
`define BIT_P2_OSC_RES 5
`define BIT_P2_XIN 6
`define BIT_P2_CRYSTAL_OUTPUT 7
`define AN_EN_WIDTH 5
`endif

//--- core/pin_mux_pkg.sv
// Types for the port pin function select block.
// Assumes nothing of its surroundings.
package pin_mux_pkg;
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pin_drive_s;
	typedef struct packed {
		logic aux_clock;
		logic sub_main_clock;
		logic timer_a_output_0;
		logic timer_a_output_1;
		logic timer_a_output_2;
	} periph_out_s;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_READ = 2'b10
	} bus_phase_e;
endpackage

//--- core/pin_edge_detect.sv
// Edge detector with sticky flag for one port-2 pin.
// Assumes its pin input is already synchronised to clk_in.
`timescale 1ns/100ps
module pin_edge_detect (
	input wire logic clk_in, // system clock
	input wire logic reset_in, // async reset, high
	input wire logic pin_in, // synchronised pin level
	input wire logic arm_in, // pin is a digital input
	input wire logic falling_in, // 1 selects falling edge
	input wire logic clear_in, // software clear
	input wire logic set_in, // software set
	output logic flag_out // sticky edge flag
);
	logic prev_q, prev_d, flag_q, flag_d, edge_hit;
	always_comb begin
		prev_d = pin_in;
		edge_hit = arm_in & (falling_in ? (prev_q & ~pin_in) : (~prev_q & pin_in));
		flag_d = flag_q;
		if (clear_in) begin
			flag_d = 1'b0;
		end
		// Hardware set wins over a clear in the same cycle.
		if (edge_hit | set_in) begin
			flag_d = 1'b1;
		end
	end
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			prev_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			flag_q <= flag_d;
		end
	end
	assign flag_out = flag_q;
endmodule

//--- verification/pin_far_side.sv
// Far-side model: the package pads seen from the board.
// Assumes the bench sets the level that the board would apply to each undriven pad.
`timescale 1ns/100ps
module pin_far_side import pin_mux_pkg::*; (
	input pin_drive_s p2_drive_in, // pad drive from the block
	input wire logic p1_out_in, // port-1 pin 7 drive
	input wire logic p1_oe_in, // port-1 pin 7 enable
	input wire logic [8:0] board_level_in, // board level, bit 8 is port-1 pin 7
	output logic [7:0] p2_pad_out, // port-2 pad levels
	output logic p1_pad_out // port-1 pin 7 pad level
);
	// A driven pad shows the block's level, otherwise the board's.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			p2_pad_out[i] = p2_drive_in.oe[i] ? p2_drive_in.out[i] : board_level_in[i];
		end
		p1_pad_out = p1_oe_in ? p1_out_in : board_level_in[8];
	end
endmodule

//--- verification/port_pin_function_select_tb.sv
// Self-checking bench for the port pin function select block.
// Assumes one AHB-Lite master, the far-side pad model and bench-driven peripherals.
`timescale 1ns/100ps
`include "pin_mux_params.svh"
module port_pin_function_select_tb import pin_mux_pkg::*;;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	pin_drive_s p2_drive;
	logic [7:0] p2_ie;
	logic [7:0] p2_pin;
	logic p1_pad, p1_out, p1_oe;
	logic tp_act = 1'b0;
	logic td_out = 1'b0;
	logic td_oe = 1'b0;
	logic td_in, cap0, cap1, tclk, ores, crystal_input, crystal_output, irq;
	logic [4:0] achan;
	periph_out_s periph = '0;
	logic [8:0] ext = 9'h0;
	logic [31:0] q;
	int n_errors = 0;
	int cmp_count = 0;

	always #25 clk_in = ~clk_in;

	port_pin_function_select u_dut (.clk_in(clk_in), .reset_in(reset_in), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.p1_pin7_in(p1_pad), .p1_pin7_out(p1_out), .p1_pin7_oe_out(p1_oe),
		.p2_pin_in(p2_pin), .p2_drive_out(p2_drive), .p2_input_enable_out(p2_ie),
		.test_port_active_in(tp_act), .test_data_out_in(td_out), .test_data_oe_in(td_oe),
		.test_data_in_out(td_in), .periph_in(periph), .timer_a_capture_input_0b_out(cap0),
		.timer_a_capture_input_1b_out(cap1), .timer_a_external_input_clock_out(tclk),
		.analog_channel_connect_out(achan), .oscillator_resistor_input_out(ores),
		.crystal_input_out(crystal_input), .crystal_output_out(crystal_output), .irq_out(irq));

	pin_far_side u_far (.p2_drive_in(p2_drive), .p1_out_in(p1_out), .p1_oe_in(p1_oe),
		.board_level_in(ext), .p2_pad_out(p2_pin), .p1_pad_out(p1_pad));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	// Address phase held until hready, then data phase; read data taken at its closing edge.
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge clk_in);
		while (hreadyout !== 1'b1) @(posedge clk_in);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk_in);
		while (hreadyout !== 1'b1) @(posedge clk_in);
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	function automatic logic [4:0] pexp(input periph_out_s p);
		return {p.timer_a_output_2, p.timer_a_output_1, p.timer_a_output_0,
			p.sub_main_clock, p.aux_clock};
	endfunction

	task end_of_test;
		$display("compares %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#200000;
		n_errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		end_of_test;
	end

	initial begin
		repeat (6) @(posedge clk_in);
		reset_in <= 1'b0;
		rd(`ADDR_P2_SEL, {24'h0, `P2_SEL_RESET});
		rd(`ADDR_P1_SEL, 32'h0);
		rd(`ADDR_AN_EN, 32'h0);
		rd(`ADDR_OSC_RES, 32'h0);
		rd(12'h030, 32'h0);
		wt(1);
		chk({crystal_input, crystal_output, p2_drive.oe[5:0], p1_oe, p2_ie}, {2'b11, 7'h0, 8'h3f});
		// Software frees the crystal output pin early when it wants a digital input.
		// early select clear
		wr(`ADDR_P2_SEL, 32'h40);
		wt(1);
		chk({crystal_input, crystal_output}, 2'b10);
		$display("reset test done");
		wr(`ADDR_P1_OUT, 32'h80);
		wr(`ADDR_P1_DIR, 32'h80);
		wt(1);
		chk({p1_oe, p1_out}, 2'b11);
		wr(`ADDR_P1_SEL, 32'h80);
		wt(1);
		chk({p1_oe, p1_out}, 2'b10);
		wr(`ADDR_P1_DIR, 32'h0);
		wr(`ADDR_P1_SEL, 32'h0);
		ext[8] <= 1'b1;
		wt(4);
		rd(`ADDR_PIN_IN, 32'h100);
		wr(`ADDR_P1_DIR, 32'h80);
		wr(`ADDR_P1_SEL, 32'h80);
		tp_act <= 1'b1;
		td_oe <= 1'b1;
		periph.timer_a_output_2 <= 1'b1;
		wt(1);
		chk({p1_oe, p1_out}, 2'b10);
		td_oe <= 1'b0;
		wt(4);
		chk(td_in, 1'b1);
		ext[8] <= 1'b0;
		wt(4);
		chk(td_in, 1'b0);
		tp_act <= 1'b0;
		$display("port-1 test done");
		wr(`ADDR_P2_DIR, 32'hff);
		wr(`ADDR_P2_SEL, 32'h7f);
		for (int i = 0; i < 2; i++) begin
			periph <= i ? 5'b01101 : 5'b10010;
			wt(1);
			chk({p2_drive.oe, p2_drive.out[5:0]}, {8'hbf, 1'b0, pexp(periph)});
		end
		wr(`ADDR_P2_DIR, 32'h0);
		for (int i = 0; i < 2; i++) begin
			ext[3:0] <= i ? 4'h5 : 4'ha;
			wt(4);
			chk({cap0, cap1, tclk, p2_drive.oe[5:0]}, {ext[2], ext[3], ext[1], 6'h0});
		end
		$display("port-2 function test done");
		wr(`ADDR_P2_DIR, 32'h3f);
		wr(`ADDR_AN_EN, 32'h1f);
		wr(`ADDR_OSC_RES, 32'h1);
		wt(1);
		chk({achan, ores, p2_drive.oe[5:0], p2_ie[5:0]}, {5'h1f, 1'b1, 12'h0});
		wr(`ADDR_AN_EN, 32'h0);
		wr(`ADDR_OSC_RES, 32'h0);
		wt(1);
		chk({achan, ores, p2_drive.oe[5:0]}, {6'h0, 6'h3f});
		$display("override test done");
		ext[3:0] <= 4'h0;
		wr(`ADDR_P2_SEL, 32'h0);
		wr(`ADDR_P2_OUT, 32'ha5);
		wr(`ADDR_P2_DIR, 32'hf0);
		wt(1);
		chk({p2_drive.oe, p2_drive.out[7:4]}, {8'hf0, 4'ha});
		wr(`ADDR_EDGE_SEL, 32'h02);
		wr(`ADDR_IRQ_EN, 32'h01);
		wr(`ADDR_IRQ_FLAG, 32'h0);
		ext[1:0] <= 2'b11;
		wt(6);
		rd(`ADDR_IRQ_FLAG, 32'h1);
		chk(irq, 1'b1);
		ext[1:0] <= 2'b00;
		wt(6);
		rd(`ADDR_IRQ_FLAG, 32'h3);
		wr(`ADDR_IRQ_FLAG, 32'h02);
		wt(1);
		chk(irq, 1'b0);
		$display("interrupt test done");
		end_of_test;
	end
endmodule
